// ===== hw/fepwm_top.sv
// Fine edge PWM channel: time base, coarse compare, fine edge window,
// delay code and calibration. The tapped delay line is a hard macro
// outside; it delays the coarse edge by fine_step_out taps when
// fine_fire is high, and reports a free-running taps-per-clock count.
`timescale 1ns/10ps
module fepwm_top #(
    parameter logic [7:0] TB_DIV = 8'h01   // System clocks per time base
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Configuration
    input  wire fepwm_pkg::fepwm_cfg_type cfg,
    input  wire logic                   cal_start,
    // Delay line interface
    input  wire logic [7:0]             tap_count,
    output logic                        pwm_out,
    output logic                        fine_fire,
    output logic [7:0]                  fine_step_out,
    output logic                        fine_miss,
    // Calibration status
    output logic                        cal_busy,
    output logic                        cal_done,
    output logic [7:0]                  fine_steps_per_clock
);
    fepwm_pkg::fepwm_top_state_type s_reg;   // Registered state
    fepwm_pkg::fepwm_top_state_type s_next;  // Next state

    logic       tb_tick;     // Time base enable pulse
    logic       wrap;        // Period ends this cycle
    logic       level;       // Coarse compare level
    logic       edge_now;    // Coarse edge this cycle
    logic [2:0] win_len;     // Window length in force
    logic       fine_open;   // Fine placement allowed
    logic [7:0] req_step;    // Requested steps
    logic [7:0] lim_step;    // Largest step below one clock
    logic [7:0] spc;         // Steps per clock in use
    logic       cal_go;      // Calibration start accepted
    logic       busy_w;      // Calibration running
    logic       busy_conc_w; // Concurrent calibration running
    logic       done_w;      // Calibration finished
    logic [7:0] result_w;    // Measured steps per clock
    logic       win_ok;      // Past the inactive window
    logic       dir_ok;      // Edge has the finely placed direction

    // Fast calibration needs fine placement off
    assign cal_go = cal_start &&
                    (cfg.cal_concurrent || !cfg.fine_enable);

    // Calibration sequencer of this channel
    fepwm_cal u_cal (
        .clk       (ref_clk),
        .rst       (rst),
        .start     (cal_go),
        .conc      (cfg.cal_concurrent),
        .sample_en (busy_conc_w ? wrap : 1'b1),
        .tap_count (s_reg.tap2),
        .busy      (busy_w),
        .busy_conc (busy_conc_w),
        .done      (done_w),
        .result    (result_w)
    );

    // Next state of time base, compare and fine edge logic
    always_comb begin
        s_next = s_reg;
        // Tap count passes two flops; macro holds it steady per clock
        s_next.tap1 = tap_count;
        s_next.tap2 = s_reg.tap1;
        // Time base divider
        tb_tick    = (s_reg.div == TB_DIV - 8'h01);
        s_next.div = tb_tick ? 8'h00 : s_reg.div + 8'h01;
        // Counter: up from zero, or down from period
        wrap = tb_tick && (cfg.count_down ? (s_reg.cnt == 16'h0000)
                                          : (s_reg.cnt >= cfg.period));
        if (tb_tick) begin
            if (wrap) begin
                s_next.cnt = cfg.count_down ? cfg.period : 16'h0000;
            end else begin
                s_next.cnt = cfg.count_down ? s_reg.cnt - 16'h0001
                                            : s_reg.cnt + 16'h0001;
            end
        end
        // Cycles since period start, saturating
        if (wrap) begin
            s_next.win = 3'h0;
        end else if (s_reg.win != fepwm_pkg::WIN_SAT) begin
            s_next.win = s_reg.win + 3'h1;
        end
        // Coarse level: compare zero gives zero duty
        level       = (s_next.cnt < cfg.coarse_compare_value);
        s_next.pwm  = level;
        edge_now    = (level != s_reg.pwm);
        // Window length depends on concurrent calibration
        s_next.wide = busy_conc_w;
        win_len     = busy_conc_w ? fepwm_pkg::WIN_CAL
                                  : fepwm_pkg::WIN_PLAIN;
        // Fine placement open only past the window, not in fast cal
        win_ok    = (s_next.win >= win_len);
        // Placed edge: falling in up mode, rising in down mode
        dir_ok    = (level == cfg.count_down);
        fine_open = cfg.fine_enable && !(busy_w && !busy_conc_w)
                    && win_ok;
        // Step count from the upper byte only
        req_step = cfg.fine_compare_value[fepwm_pkg::FINE_MSB:
                                          fepwm_pkg::FINE_LSB];
        // Clamp so the delay stays inside one clock
        spc      = (s_reg.result == 8'h00) ? fepwm_pkg::SPC_DEFAULT
                                           : s_reg.result;
        lim_step = spc - 8'h01;
        // Fine edge only on the placed edge, with a nonzero code
        s_next.fire = edge_now && dir_ok && fine_open
                      && (req_step != 8'h00);
        s_next.step = s_next.fire ? ((req_step > lim_step) ? lim_step
                                                           : req_step)
                                  : 8'h00;
        // Edge inside window keeps coarse timing only
        s_next.miss = edge_now && dir_ok && cfg.fine_enable
                      && (req_step != 8'h00) && !win_ok;
        // Calibration status, one cycle behind the sequencer
        s_next.busy = busy_w;
        s_next.done = done_w;
        if (done_w) begin
            s_next.result = result_w;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pwm_out              = s_reg.pwm;
    assign fine_fire            = s_reg.fire;
    assign fine_step_out        = s_reg.step;
    assign fine_miss            = s_reg.miss;
    assign cal_busy             = s_reg.busy;
    assign cal_done             = s_reg.done;
    assign fine_steps_per_clock = s_reg.result;

    // Assertions share the system clock and its reset
    default clocking fepwm_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Fine edge never within three cycles of period start
    fire_plain_a: assert property (
        fine_fire |-> s_reg.win >= fepwm_pkg::WIN_PLAIN)
        else $error("fine edge inside three-cycle window");

    // Six-cycle window while concurrent calibration runs
    fire_wide_a: assert property (
        (fine_fire && s_reg.wide) |-> s_reg.win >= fepwm_pkg::WIN_CAL)
        else $error("fine edge inside six-cycle window");

    // Lost fine edges lie inside the window and are not fired
    miss_window_a: assert property (
        fine_miss |-> !fine_fire && s_reg.win <
            (s_reg.wide ? fepwm_pkg::WIN_CAL : fepwm_pkg::WIN_PLAIN))
        else $error("fine edge lost outside window");

    // Coarse level follows counter against compare
    coarse_level_a: assert property (
        !$past(rst) |->
            pwm_out == (s_reg.cnt < $past(cfg.coarse_compare_value)))
        else $error("coarse level does not match compare");

    // Down mode fine edge is a rising edge
    sequence down_edge_s;
        $past(cfg.count_down) && fine_fire;
    endsequence
    down_rise_a: assert property (
        down_edge_s |-> pwm_out && !$past(pwm_out))
        else $error("down mode fine edge not rising");

    // Up mode fine edge is a falling edge
    up_fall_a: assert property (
        (!$past(cfg.count_down) && fine_fire) |-> !pwm_out && $past(pwm_out))
        else $error("up mode fine edge not falling");

    // Down mode loses only the early rising edge: the high duty limit
    down_limit_a: assert property (
        ($past(cfg.count_down) && fine_miss) |-> pwm_out && !$past(pwm_out))
        else $error("down mode lost edge not rising");

    // Step nonzero, from the upper byte, below one clock
    step_range_a: assert property (
        fine_fire |-> fine_step_out != 8'h00 && fine_step_out <=
            $past(cfg.fine_compare_value[fepwm_pkg::FINE_MSB:
                                         fepwm_pkg::FINE_LSB])
            && fine_step_out < $past(spc))
        else $error("fine step out of range");

    // Delay code stays zero between fine edges
    step_idle_a: assert property (
        !fine_fire |-> fine_step_out == 8'h00)
        else $error("delay code without fine edge");

    // No fine edge while fast calibration runs
    sequence fast_cal_s;
        busy_w && !busy_conc_w;
    endsequence
    fast_excl_a: assert property (
        fast_cal_s |=> !fine_fire)
        else $error("fine edge during fast calibration");

    // Latched measurement follows the finished run
    result_take_a: assert property (
        done_w |=> cal_done && fine_steps_per_clock == $past(result_w))
        else $error("measurement not latched");

    // Busy output trails the sequencer by one cycle
    busy_follow_a: assert property (
        cal_busy == $past(busy_w))
        else $error("calibration busy out of step");
endmodule

// ===== hw/fepwm_pkg.sv
// Constants, carrier structs and state types of the fine edge PWM block.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
//
// Behaviour
// - Fine edges blocked first 3 cycles of period
// - Six-cycle block while calibration runs concurrently
// - Window limits only fine placement at low duty
// - Coarse duty works down to zero percent
// - Count-down mode places rising edge finely
// - Count-down mode gives matching maximum duty limit
// - Fine edge uses up to steps per clock minus one steps
// - Channel has own steps-per-clock measurement logic
// - Fast calibration only with fine placement off
// - Result counts delay steps per system clock
// - Step count comes from compare upper byte
package fepwm_pkg;

    // Clock and delay step timing
    localparam int CLK_PERIOD_PS = 25000;   // 40 MHz system clock
    localparam int STEP_PS       = 150;     // Nominal delay step
    localparam logic [7:0] SPC_DEFAULT =
        8'(CLK_PERIOD_PS / STEP_PS);        // Steps per clock, uncalibrated

    // Inactive windows, counted in system clocks from period start
    localparam logic [2:0] WIN_PLAIN = 3'h3;
    localparam logic [2:0] WIN_CAL   = 3'h6;
    localparam logic [2:0] WIN_SAT   = 3'h7;

    // Fine compare layout: step count in the upper byte
    localparam int FINE_LSB = 8;
    localparam int FINE_MSB = 15;

    // Calibration averaging
    localparam logic [3:0] CAL_SAMPLES = 4'h8;
    localparam int         CAL_SHIFT   = 3;

    // Configuration carried into the block
    typedef struct packed {
        logic        count_down;            // Down counting, rising edge fine
        logic        fine_enable;           // Fine edge placement on
        logic        cal_concurrent;        // Slow calibration beside fine
        logic [15:0] period;                // Period in time base counts
        logic [15:0] coarse_compare_value;  // Coarse edge count
        logic [15:0] fine_compare_value;    // Fine steps in upper byte
    } fepwm_cfg_type;

    // Calibration sequencer states
    typedef enum logic {CAL_IDLE, CAL_RUN} fepwm_cal_st_type;

    // Calibration module state
    typedef struct packed {
        fepwm_cal_st_type st;
        logic             busy;
        logic             conc;             // Run is the concurrent kind
        logic             done;
        logic [3:0]       n;                // Samples taken
        logic [10:0]      acc;              // Sum of samples
        logic [7:0]       result;           // Steps per system clock
    } fepwm_cal_state_type;

    // Top module state
    typedef struct packed {
        logic [7:0]  div;                   // Time base divider
        logic [15:0] cnt;                   // Time base counter
        logic [2:0]  win;                   // Cycles since period start
        logic        wide;                  // Six-cycle window in force
        logic        pwm;                   // Coarse output level
        logic        fire;                  // Fine edge issued this cycle
        logic [7:0]  step;                  // Fine delay code
        logic        miss;                  // Fine edge lost to window
        logic [7:0]  tap1;                  // Tap count synchroniser
        logic [7:0]  tap2;
        logic        busy;                  // Calibration busy, delayed
        logic        done;                  // Calibration done, delayed
        logic [7:0]  result;                // Latched steps per clock
    } fepwm_top_state_type;

endpackage

// ===== hw/fepwm_cal.sv
// Steps-per-clock measurement of one fine edge channel.
// Assumes tap counts already synchronised to the system clock.
`timescale 1ns/10ps
module fepwm_cal (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       start,
    input  wire logic       conc,
    input  wire logic       sample_en,
    input  wire logic [7:0] tap_count,
    // Status
    output logic            busy,
    output logic            busy_conc,
    output logic            done,
    output logic [7:0]      result
);
    fepwm_pkg::fepwm_cal_state_type s_reg;   // Registered state
    fepwm_pkg::fepwm_cal_state_type s_next;  // Next state

    // Sequencer: sum a fixed number of samples, then average
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            fepwm_pkg::CAL_IDLE: begin
                // Start latches the run kind
                if (start) begin
                    s_next.st   = fepwm_pkg::CAL_RUN;
                    s_next.busy = 1'b1;
                    s_next.conc = conc;
                    s_next.n    = 4'h0;
                    s_next.acc  = 11'h000;
                end
            end
            fepwm_pkg::CAL_RUN: begin
                // One sample per enable; period rate when concurrent
                if (sample_en) begin
                    s_next.acc = s_reg.acc + {3'h0, tap_count};
                    s_next.n   = s_reg.n + 4'h1;
                    if (s_reg.n + 4'h1 == fepwm_pkg::CAL_SAMPLES) begin
                        s_next.st     = fepwm_pkg::CAL_IDLE;
                        s_next.busy   = 1'b0;
                        s_next.done   = 1'b1;
                        s_next.result = 8'(s_next.acc >>
                                           fepwm_pkg::CAL_SHIFT);
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy      = s_reg.busy;
    assign busy_conc = s_reg.busy & s_reg.conc;
    assign done      = s_reg.done;
    assign result    = s_reg.result;

    // Result is the average of the summed samples
    cal_average_a: assert property (@(posedge clk) disable iff (rst)
        $rose(done) |-> result == 8'(s_reg.acc >> fepwm_pkg::CAL_SHIFT))
        else $error("calibration result not the sample average");

    // A run ends in done, never done without a run
    cal_done_a: assert property (@(posedge clk) disable iff (rst)
        done |-> $past(busy) && !busy)
        else $error("calibration done without a run");
endmodule

// ===== dv/tb_fepwm_top.sv
// Self-checking bench for the fine edge PWM channel top.
// Assumes TB_DIV of one, so time base equals the 40 MHz system clock.
`timescale 1ns/10ps
module tb_fepwm_top;

    // Stimulus and observed signals
    logic                    ref_clk;
    logic                    rst;
    fepwm_pkg::fepwm_cfg_type cfg;
    logic                    cal_start;
    logic [7:0]              tap_count;
    logic                    pwm_out;
    logic                    fine_fire;
    logic [7:0]              fine_step_out;
    logic                    fine_miss;
    logic                    cal_busy;
    logic                    cal_done;
    logic [7:0]              fine_steps_per_clock;
    int                      miscompares;   // Mismatches seen
    int                      checks;        // Comparisons made
    int                      cyc;           // Cycle count for timeout

    // Device under test
    // Time base equals system clock, so the result needs no scaling
    fepwm_top #(.TB_DIV(8'h01)) u_fepwm_top (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .cfg                  (cfg),
        .cal_start            (cal_start),
        .tap_count            (tap_count),
        .pwm_out              (pwm_out),
        .fine_fire            (fine_fire),
        .fine_step_out        (fine_step_out),
        .fine_miss            (fine_miss),
        .cal_busy             (cal_busy),
        .cal_done             (cal_done),
        .fine_steps_per_clock (fine_steps_per_clock)
    );

    // Clock of 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task close_out;
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end

    // Single comparison point
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle calibration request
    task pulse_start;
        @(negedge ref_clk);
        cal_start = 1'b1;
        @(negedge ref_clk);
        cal_start = 1'b0;
    endtask

    // Find next edge of given direction; report fire, miss, code
    task see_edge(input logic rise, output logic f, output logic m,
                  output logic [7:0] s);
        logic prev;
        f = 1'b0;
        m = 1'b0;
        s = 8'h00;
        prev = pwm_out;
        for (int i = 0; i < 200; i++) begin
            @(negedge ref_clk);
            if (pwm_out === rise && prev === !rise) begin
                f = fine_fire;
                m = fine_miss;
                s = fine_step_out;
                return;
            end
            prev = pwm_out;
        end
        // No edge of that direction within the limit
        check(16'h0000, 16'h0001);
    endtask

    // Set mode and compares, judge the second edge after the change
    task run_edge(input logic cd, input logic [15:0] cmp,
                  input logic [15:0] fine, input logic exp_fire,
                  input logic [7:0] exp_step);
        logic       f;
        logic       m;
        logic [7:0] s;
        @(negedge ref_clk);
        cfg.count_down           = cd;
        cfg.coarse_compare_value = cmp;
        cfg.fine_compare_value   = fine;
        see_edge(cd, f, m, s);
        see_edge(cd, f, m, s);
        check({15'h0000, f}, {15'h0000, exp_fire});
        check({15'h0000, m}, {15'h0000, !exp_fire});
        check({8'h00, s}, {8'h00, exp_fire ? exp_step : 8'h00});
    endtask

    // Coarse duty: high cycles over one full period of 21 counts
    task duty(input logic [15:0] cmp);
        int hi;
        int fires;
        @(negedge ref_clk);
        cfg.coarse_compare_value = cmp;
        repeat (42) @(negedge ref_clk);
        hi = 0;
        fires = 0;
        for (int i = 0; i < 21; i++) begin
            @(negedge ref_clk);
            hi += (pwm_out === 1'b1);
            fires += (fine_fire !== 1'b0);
        end
        check(16'(hi), cmp);
        check(16'(fires), 16'h0000);
    endtask

    // Calibration run and its result
    task calibrate(input logic [7:0] taps, input int limit);
        int busy_seen;
        busy_seen = 0;
        tap_count = taps;
        pulse_start();
        for (int i = 0; i < limit && cal_done !== 1'b1; i++) begin
            @(negedge ref_clk);
            busy_seen += (cal_busy === 1'b1);
        end
        check({15'h0000, cal_done}, 16'h0001);
        check({8'h00, fine_steps_per_clock}, {8'h00, taps});
        check(16'(busy_seen > 0), 16'h0001);
    endtask

    // Fast calibration refused while fine placement is on
    task refused_cal;
        int act;
        act = 0;
        pulse_start();
        repeat (14) begin
            @(negedge ref_clk);
            act += (cal_busy !== 1'b0) + (cal_done !== 1'b0);
        end
        check(16'(act), 16'h0000);
    endtask

    // Concurrent calibration widens window to six cycles
    task conc_cal;
        @(negedge ref_clk);
        cfg.cal_concurrent = 1'b1;
        tap_count = 8'h50;
        pulse_start();
        run_edge(1'b0, 16'h0005, 16'h0900, 1'b0, 8'h00);
        run_edge(1'b0, 16'h0006, 16'h0900, 1'b1, 8'h09);
        check({15'h0000, cal_busy}, 16'h0001);
        // One sample per period: wait out the eight periods
        for (int i = 0; i < 400 && cal_done !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        check({15'h0000, cal_done}, 16'h0001);
        check({15'h0000, cal_busy}, 16'h0000);
        check({8'h00, fine_steps_per_clock}, 16'h0050);
        cfg.cal_concurrent = 1'b0;
        run_edge(1'b0, 16'h0005, 16'hFF00, 1'b1, 8'h4F);
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        checks = 0;
        cyc = 0;
        rst = 1'b1;
        cal_start = 1'b0;
        tap_count = 8'h42;
        cfg = '0;
        cfg.period = 16'h0014;
        repeat (10) @(negedge ref_clk);
        check({3'h0, pwm_out, fine_fire, fine_miss, cal_busy, cal_done,
               fine_steps_per_clock}, 16'h0000);
        check({8'h00, fine_step_out}, 16'h0000);
        rst = 1'b0;
        duty(16'h0000);
        duty(16'h0001);
        duty(16'h0005);
        cfg.fine_enable = 1'b1;
        run_edge(1'b0, 16'h0005, 16'h17AB, 1'b1, 8'h17);
        run_edge(1'b0, 16'h0003, 16'h0900, 1'b1, 8'h09);
        run_edge(1'b0, 16'h0002, 16'h0900, 1'b0, 8'h00);
        run_edge(1'b0, 16'h0005, 16'hFF00, 1'b1, 8'hA5);
        run_edge(1'b1, 16'h000A, 16'h2000, 1'b1, 8'h20);
        run_edge(1'b1, 16'h0012, 16'h2000, 1'b1, 8'h20);
        run_edge(1'b1, 16'h0013, 16'h2000, 1'b0, 8'h00);
        refused_cal();
        cfg.count_down = 1'b0;
        cfg.fine_enable = 1'b0;
        calibrate(8'h42, 30);
        cfg.fine_enable = 1'b1;
        run_edge(1'b0, 16'h0005, 16'hFF00, 1'b1, 8'h41);
        conc_cal();
        close_out();
    end

endmodule
